// [rtl/tmpc_defs.svh]
`ifndef TMPC_DEFS_SVH
`define TMPC_DEFS_SVH
// register addresses on the serial configuration port
`define TMPC_ADDR_MODE 7'h00
`define TMPC_ADDR_IFC 7'h01
// reset values
`define TMPC_MODE_RESET 8'h00
`define TMPC_IFC_RESET 8'h00
// mode register fields
`define TMPC_MODE_TX 7
`define TMPC_MODE_FSET 6
`define TMPC_MODE_PDM_HI 5
`define TMPC_MODE_PDM_LO 4
`define TMPC_MODE_B3 3
`define TMPC_MODE_B2 2
`define TMPC_MODE_B1 1
`define TMPC_MODE_RSTN 0
// interface register fields
`define TMPC_IFC_BYPASS 7
`define TMPC_IFC_SEP 6
`define TMPC_IFC_GLOCK 5
`define TMPC_IFC_GCS 4
`define TMPC_IFC_EXTTX 3
`define TMPC_IFC_EXTRX 2
`define TMPC_IFC_TXPOL 1
`define TMPC_IFC_RXPOL 0
// calibration counter terminal values
`define TMPC_CNT16_LAST 8'h0f
`define TMPC_CNT256_LAST 8'hff
`define TMPC_TEST_MODE_IDLE 3'h1
// serial frame: 8 address/direction bits then 8 data bits
`define TMPC_SER_LAST_BIT 4'h7
`endif

// [rtl/tmpc_pkg.sv]
package tmpc_pkg;
    typedef enum logic [1:0] {
        PdModeSplit, PdModeBoth, PdModeIndividual, PdModeSequence
    } tmpc_power_down_mode_t;
    typedef enum logic [1:0] {
        CalNever, CalEvery, CalEvery16, CalEvery256
    } tmpc_cal_policy_t;
    typedef enum logic [1:0] {SerIdle, SerAddr, SerData} tmpc_ser_state_t;
    typedef struct packed {
        tmpc_ser_state_t serState;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [6:0] addr;
        logic isWrite;
        logic cfgClkMeta, cfgClkSync, cfgClkLast;
        logic cfgSelMeta, cfgSelSync, cfgSelLast;
        logic cfgDinMeta, cfgDinSync;
        logic dataIoMeta, dataIoSync, dataIoLast;
        logic [7:0] mode;
        logic [7:0] ifc;
        logic [7:0] seqCount;
        logic configDataOut, dataIoPinOut, dataIoPinOe, txData, lockPin;
        logic dataClockPin, txAmpEnablePin, rxAmpEnablePin;
        logic testModulePowerDown;
        logic [2:0] testMode;
        logic txSelect, freqSetB, synthPowerDown, oscCorePowerDown;
        logic biasPowerDown, oscillatorBypass, sequenceEnable;
        tmpc_cal_policy_t sequenceCalPolicy;
        logic sequenceStart, sequencePowerDown, calRequest, softResetN;
    } tmpc_state_t;
endpackage : tmpc_pkg

// [rtl/tmpc_mode_pin_regs.sv]
`timescale 1ns/1ps
`include "tmpc_defs.svh"

// Contract
// - sequencing runs only with receive selected; host keeps receive while sequencing
// - sequencing enabled only when power-down mode is 11; bits 3..1 change meaning
// - frequency-set bit picks word set A at 0, set B at 1
// - calibration policy: never, every sequence, every 16th, every 256th
// - rising sequence power-down bit enters power-down awaiting next trigger
// - writing soft reset bit 0 restores defaults of all but mode register
// - mode register has no default; bits take the written values; here the hard reset loads 8'h00
// - oscillator bypass defaults 0; at 1 internal oscillator powered down
// - shared data pin: drives rx data in receive, takes tx data in transmit
// - separate data pin: pin input only; rx data on lock or clock pin
// - data pin falling edges start sequencing when separate, pin-select unused, mode 3
// - lock gating in mode 01 holds data clock high unless PLL locked
// - carrier gating holds data clock high unless carrier sensed
// - tx amp pin equals polarity at 0, asserts with internal amp at 1
// - rx amp pin equals polarity at 0, asserts with internal amp at 1
// - tx amp polarity bit sets pin active level, 1 active high
// - rx amp polarity bit sets pin active level, 1 active high
// - test enable: low interface bits drive test controls, else 1 and 001
// - select-pin falling edges start sequencing only when pin use bit set
// - normal layout: bit 7 rx/tx, bits 3..1 power down synth, osc, bias
module tmpc_mode_pin_regs (
    input wire logic clock,
    input wire logic reset,
    input wire logic configClock,
    input wire logic configSelectN,
    input wire logic configDataIn,
    input wire logic dataIoPinIn,
    input wire logic rxData,
    input wire logic pllLock,
    input wire logic carrierSense,
    input wire logic syncMode,
    input wire logic syncDataClock,
    input wire logic internalTxAmpOn,
    input wire logic internalRxAmpOn,
    input wire logic analogTestEnableF,
    input wire logic analogTestEnableA,
    input wire logic sequenceSelectPinUse,
    input wire logic sequenceDone,
    output logic configDataOut,
    output logic dataIoPinOut,
    output logic dataIoPinOe,
    output logic txData,
    output logic lockPin,
    output logic dataClockPin,
    output logic txAmpEnablePin,
    output logic rxAmpEnablePin,
    output logic testModulePowerDown,
    output logic [2:0] testMode,
    output logic txSelect,
    output logic freqSetB,
    output logic synthPowerDown,
    output logic oscCorePowerDown,
    output logic biasPowerDown,
    output logic oscillatorBypass,
    output logic sequenceEnable,
    output tmpc_pkg::tmpc_cal_policy_t sequenceCalPolicy,
    output logic sequenceStart,
    output logic sequencePowerDown,
    output logic calRequest,
    output logic softResetN
);
    import tmpc_pkg::*;

    tmpc_state_t s_q;
    tmpc_state_t s_d;

    always_comb begin
        logic clkRise;
        logic clkFall;
        logic selFall;
        logic [7:0] shiftIn;
        logic [7:0] readWord;
        logic seqLayout;
        logic seqOn;
        logic gateHigh;
        tmpc_power_down_mode_t pdm;
        clkRise = 1'b0;
        clkFall = 1'b0;
        selFall = 1'b0;
        shiftIn = 8'h00;
        readWord = 8'h00;
        seqLayout = 1'b0;
        seqOn = 1'b0;
        gateHigh = 1'b0;
        pdm = PdModeSplit;
        s_d = s_q;

        // pin synchronisers; the second stage is used, and edges compare it with the third
        s_d.cfgClkMeta = configClock;
        s_d.cfgClkSync = s_q.cfgClkMeta;
        s_d.cfgClkLast = s_q.cfgClkSync;
        s_d.cfgSelMeta = configSelectN;
        s_d.cfgSelSync = s_q.cfgSelMeta;
        s_d.cfgSelLast = s_q.cfgSelSync;
        s_d.cfgDinMeta = configDataIn;
        s_d.cfgDinSync = s_q.cfgDinMeta;
        s_d.dataIoMeta = dataIoPinIn;
        s_d.dataIoSync = s_q.dataIoMeta;
        s_d.dataIoLast = s_q.dataIoSync;
        clkRise = s_q.cfgClkSync & ~s_q.cfgClkLast;
        clkFall = ~s_q.cfgClkSync & s_q.cfgClkLast;
        selFall = ~s_q.cfgSelSync & s_q.cfgSelLast;
        shiftIn = {s_q.shift[6:0], s_q.cfgDinSync};

        // mode decode follows the stored field directly
        pdm = tmpc_power_down_mode_t'(s_q.mode[`TMPC_MODE_PDM_HI:`TMPC_MODE_PDM_LO]);
        seqLayout = (pdm == PdModeSequence);
        seqOn = seqLayout & ~s_q.mode[`TMPC_MODE_TX];

        s_d.sequenceStart = 1'b0;
        s_d.sequencePowerDown = 1'b0;
        s_d.calRequest = 1'b0;

        // serial frame engine: 7 address bits, direction, 8 data bits
        case (s_q.serState)
            SerIdle: begin
                if (selFall) begin
                    s_d.serState = SerAddr;
                    s_d.bitCnt = 4'h0;
                end
            end
            SerAddr: begin
                if (clkRise) begin
                    s_d.shift = shiftIn;
                    s_d.bitCnt = s_q.bitCnt + 4'h1;
                    if (s_q.bitCnt == `TMPC_SER_LAST_BIT) begin
                        s_d.addr = shiftIn[7:1];
                        s_d.isWrite = shiftIn[0];
                        s_d.bitCnt = 4'h0;
                        s_d.serState = SerData;
                        if (shiftIn[7:1] == `TMPC_ADDR_MODE) begin
                            readWord = s_q.mode;
                        end else if (shiftIn[7:1] == `TMPC_ADDR_IFC) begin
                            readWord = s_q.ifc;
                        end
                        // unmapped addresses read as zero
                        s_d.shift = readWord;
                        s_d.configDataOut = readWord[7] & ~shiftIn[0];
                    end
                end
            end
            SerData: begin
                if (clkRise) begin
                    s_d.bitCnt = s_q.bitCnt + 4'h1;
                    if (s_q.isWrite) begin
                        s_d.shift = shiftIn;
                    end
                    if (s_q.bitCnt == `TMPC_SER_LAST_BIT) begin
                        s_d.serState = SerIdle;
                        if (s_q.isWrite && s_q.addr == `TMPC_ADDR_MODE) begin
                            s_d.mode = shiftIn;
                            if (shiftIn[`TMPC_MODE_B1] && !s_q.mode[`TMPC_MODE_B1]
                                && shiftIn[5:4] == 2'b11) begin
                                s_d.sequencePowerDown = 1'b1;
                            end
                        end else if (s_q.isWrite && s_q.addr == `TMPC_ADDR_IFC) begin
                            s_d.ifc = shiftIn;
                        end
                    end
                end else if (clkFall && !s_q.isWrite && s_q.bitCnt != 4'h0) begin
                    // next read bit presented on the falling edge
                    s_d.configDataOut = s_q.shift[3'h7 - s_q.bitCnt[2:0]];
                end
            end
            default: begin
                s_d.serState = SerIdle;
            end
        endcase
        // deselect aborts a partial frame; a half word is never stored
        if (s_q.cfgSelSync) begin
            s_d.serState = SerIdle;
            s_d.configDataOut = 1'b0;
        end

        // interface register held at defaults while soft reset is low
        if (!s_d.mode[`TMPC_MODE_RSTN]) begin
            s_d.ifc = `TMPC_IFC_RESET;
        end
        s_d.softResetN = s_q.mode[`TMPC_MODE_RSTN];

        // sequence triggers
        if (selFall && sequenceSelectPinUse && seqOn) begin
            s_d.sequenceStart = 1'b1;
        end
        if (~s_q.dataIoSync & s_q.dataIoLast & s_q.ifc[`TMPC_IFC_SEP]
            & ~sequenceSelectPinUse & seqOn) begin
            s_d.sequenceStart = 1'b1;
        end

        // calibration decimation counts finished sequences
        if (sequenceDone && seqOn) begin
            s_d.seqCount = s_q.seqCount + 8'h01;
            case (tmpc_cal_policy_t'(s_q.mode[3:2]))
                CalNever: s_d.calRequest = 1'b0;
                CalEvery: s_d.calRequest = 1'b1;
                CalEvery16: s_d.calRequest = (s_q.seqCount[3:0] == `TMPC_CNT16_LAST);
                CalEvery256: s_d.calRequest = (s_q.seqCount == `TMPC_CNT256_LAST);
                default: s_d.calRequest = 1'b0;
            endcase
        end

        // mode outputs, two layouts of bits 3..1
        s_d.txSelect = s_q.mode[`TMPC_MODE_TX];
        s_d.freqSetB = s_q.mode[`TMPC_MODE_FSET];
        s_d.synthPowerDown = ~seqLayout & s_q.mode[`TMPC_MODE_B3];
        s_d.oscillatorBypass = s_q.ifc[`TMPC_IFC_BYPASS];
        s_d.oscCorePowerDown = s_q.ifc[`TMPC_IFC_BYPASS]
            | (~seqLayout & s_q.mode[`TMPC_MODE_B2]);
        s_d.biasPowerDown = ~seqLayout & s_q.mode[`TMPC_MODE_B1];
        s_d.sequenceEnable = seqOn;
        s_d.sequenceCalPolicy = seqLayout ? tmpc_cal_policy_t'(s_q.mode[3:2]) : CalNever;

        // data pin direction and routing
        s_d.dataIoPinOe = ~s_q.ifc[`TMPC_IFC_SEP] & ~s_q.mode[`TMPC_MODE_TX];
        s_d.dataIoPinOut = rxData;
        s_d.txData = s_q.dataIoSync & (s_q.mode[`TMPC_MODE_TX] | s_q.ifc[`TMPC_IFC_SEP]);
        s_d.lockPin = (s_q.ifc[`TMPC_IFC_SEP] && syncMode) ? rxData : pllLock;

        // data clock gating; a gated clock idles high
        gateHigh = (s_q.ifc[`TMPC_IFC_GLOCK] && pdm == PdModeBoth && !pllLock)
            || (s_q.ifc[`TMPC_IFC_GCS] && !carrierSense);
        if (s_q.ifc[`TMPC_IFC_SEP] && !syncMode) begin
            s_d.dataClockPin = rxData;
        end else begin
            s_d.dataClockPin = gateHigh | syncDataClock;
        end

        // external amplifier pins
        s_d.txAmpEnablePin = s_q.ifc[`TMPC_IFC_EXTTX]
            ? (internalTxAmpOn ~^ s_q.ifc[`TMPC_IFC_TXPOL])
            : s_q.ifc[`TMPC_IFC_TXPOL];
        s_d.rxAmpEnablePin = s_q.ifc[`TMPC_IFC_EXTRX]
            ? (internalRxAmpOn ~^ s_q.ifc[`TMPC_IFC_RXPOL])
            : s_q.ifc[`TMPC_IFC_RXPOL];

        // analog test borrows the low interface bits
        if (analogTestEnableF || analogTestEnableA) begin
            s_d.testModulePowerDown = s_q.ifc[3];
            s_d.testMode = s_q.ifc[2:0];
        end else begin
            s_d.testModulePowerDown = 1'b1;
            s_d.testMode = `TMPC_TEST_MODE_IDLE;
        end
    end

    // single state register; mode is cleared only by the hard reset
    always_ff @(posedge clock) begin
        if (reset) begin
            s_q <= '0;
            s_q.serState <= SerIdle;
            s_q.mode <= `TMPC_MODE_RESET;
            s_q.ifc <= `TMPC_IFC_RESET;
            s_q.cfgSelMeta <= 1'b1;
            s_q.cfgSelSync <= 1'b1;
            s_q.cfgSelLast <= 1'b1;
            s_q.testModulePowerDown <= 1'b1;
            s_q.testMode <= `TMPC_TEST_MODE_IDLE;
            s_q.dataClockPin <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign configDataOut = s_q.configDataOut;
    assign dataIoPinOut = s_q.dataIoPinOut;
    assign dataIoPinOe = s_q.dataIoPinOe;
    assign txData = s_q.txData;
    assign lockPin = s_q.lockPin;
    assign dataClockPin = s_q.dataClockPin;
    assign txAmpEnablePin = s_q.txAmpEnablePin;
    assign rxAmpEnablePin = s_q.rxAmpEnablePin;
    assign testModulePowerDown = s_q.testModulePowerDown;
    assign testMode = s_q.testMode;
    assign txSelect = s_q.txSelect;
    assign freqSetB = s_q.freqSetB;
    assign synthPowerDown = s_q.synthPowerDown;
    assign oscCorePowerDown = s_q.oscCorePowerDown;
    assign biasPowerDown = s_q.biasPowerDown;
    assign oscillatorBypass = s_q.oscillatorBypass;
    assign sequenceEnable = s_q.sequenceEnable;
    assign sequenceCalPolicy = s_q.sequenceCalPolicy;
    assign sequenceStart = s_q.sequenceStart;
    assign sequencePowerDown = s_q.sequencePowerDown;
    assign calRequest = s_q.calRequest;
    assign softResetN = s_q.softResetN;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence dataIoFall;
        s_q.dataIoLast && !s_q.dataIoSync;
    endsequence
    sequence pinStartReady;
        s_q.ifc[6] && !sequenceSelectPinUse && s_q.mode[5:4] == 2'b11 && !s_q.mode[7];
    endsequence

    a_pin_seq_start: assert property ((dataIoFall and pinStartReady) |=> sequenceStart)
        else $error("data pin edge did not start sequencing");
    a_seq_enable_mode: assert property (##1 sequenceEnable ==
        ($past(s_q.mode[5:4]) == 2'b11 && !$past(s_q.mode[7])))
        else $error("sequence enable does not follow mode");
    a_soft_reset_ifc: assert property (!s_q.mode[0] |-> s_q.ifc == `TMPC_IFC_RESET)
        else $error("interface register not at default in soft reset");
    a_lock_gate_high: assert property ((s_q.ifc[5] && s_q.mode[5:4] == 2'b01
        && !pllLock && !(s_q.ifc[6] && !syncMode)) |=> dataClockPin)
        else $error("data clock not held high without lock");
    a_carrier_gate: assert property ((s_q.ifc[4] && !carrierSense
        && !(s_q.ifc[6] && !syncMode)) |=> dataClockPin)
        else $error("data clock not held high without carrier");
    a_sep_pin_input: assert property (s_q.ifc[6] |=> !dataIoPinOe)
        else $error("data pin driven in separate mode");
    a_tx_amp_level: assert property (##1 txAmpEnablePin == ($past(s_q.ifc[3])
        ? ($past(internalTxAmpOn) == $past(s_q.ifc[1])) : $past(s_q.ifc[1])))
        else $error("tx amp pin wrong");
    a_rx_amp_level: assert property (##1 rxAmpEnablePin == ($past(s_q.ifc[2])
        ? ($past(internalRxAmpOn) == $past(s_q.ifc[0])) : $past(s_q.ifc[0])))
        else $error("rx amp pin wrong");
    a_test_idle_val: assert property (!(analogTestEnableF || analogTestEnableA)
        |=> testModulePowerDown && testMode == 3'h1)
        else $error("test controls not idle");
    a_cal_every_seq: assert property ((sequenceDone && s_q.sequenceEnable
        && s_q.mode[3:2] == 2'b01 && s_q.mode[5:4] == 2'b11 && !s_q.mode[7]) |=> calRequest)
        else $error("calibration missed");
endmodule : tmpc_mode_pin_regs

// [verification/tmpc_host_model.sv]
`timescale 1ns/1ps
// host side of the serial configuration port
module tmpc_host_model (
    output logic configClock,
    output logic configSelectN,
    output logic configDataIn,
    input wire logic configDataOut
);
    // link clock stands still low between frames
    initial begin
        configClock = 1'b0;
        configSelectN = 1'b1;
        configDataIn = 1'b0;
    end

    // 7 address bits, direction, 8 data bits, msb first, 320 ns link period
    task automatic frame(input logic wr, input logic [6:0] a, input logic [7:0] d,
        output logic [7:0] q);
        logic [15:0] w;
        w = {a, wr, d};
        q = 8'h00;
        configSelectN = 1'b0;
        #200;
        for (int i = 15; i >= 0; i--) begin
            configDataIn = w[i];
            #40 configClock = 1'b1;
            #160 configClock = 1'b0;
            // read bits taken late in the low phase, after the synced fall has updated them
            #120 if (i >= 1 && i <= 8) q[i - 1] = configDataOut;
        end
        #200 configSelectN = 1'b1;
        configDataIn = ~configDataIn; // released line shows no stale value
        #400;
    endtask : frame
endmodule : tmpc_host_model

// [verification/tmpc_mode_pin_regs_bench.sv]
`timescale 1ns/1ps
`include "tmpc_defs.svh"
module tmpc_mode_pin_regs_bench;
    import tmpc_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic configClock, configSelectN, configDataIn, configDataOut;
    logic dataIoPinIn = 1'b1, rxData = 1'b0, pllLock = 1'b0, carrierSense = 1'b0;
    logic syncMode = 1'b1, syncDataClock = 1'b0, txOn = 1'b0, rxOn = 1'b0;
    logic tfEn = 1'b0, taEn = 1'b0, selUse = 1'b0, sequenceDone = 1'b0;
    logic dataIoPinOut, dataIoPinOe, txData, lockPin, dataClockPin, txAmpEnablePin;
    logic rxAmpEnablePin, testModulePowerDown, txSelect, freqSetB, synthPowerDown;
    logic oscCorePowerDown, biasPowerDown, oscillatorBypass, sequenceEnable;
    logic sequenceStart, sequencePowerDown, calRequest, softResetN;
    logic [2:0] testMode;
    tmpc_cal_policy_t sequenceCalPolicy;
    int fails = 0, testsRun = 0, nStart = 0, nPd = 0, nCal = 0;

    tmpc_host_model u_tmpc_host_model (.configClock(configClock),
        .configSelectN(configSelectN), .configDataIn(configDataIn),
        .configDataOut(configDataOut));
    tmpc_mode_pin_regs u_tmpc_mode_pin_regs (.clock(clock), .reset(reset),
        .configClock(configClock), .configSelectN(configSelectN),
        .configDataIn(configDataIn), .dataIoPinIn(dataIoPinIn), .rxData(rxData),
        .pllLock(pllLock), .carrierSense(carrierSense), .syncMode(syncMode),
        .syncDataClock(syncDataClock), .internalTxAmpOn(txOn), .internalRxAmpOn(rxOn),
        .analogTestEnableF(tfEn), .analogTestEnableA(taEn),
        .sequenceSelectPinUse(selUse), .sequenceDone(sequenceDone),
        .configDataOut(configDataOut), .dataIoPinOut(dataIoPinOut),
        .dataIoPinOe(dataIoPinOe), .txData(txData), .lockPin(lockPin),
        .dataClockPin(dataClockPin), .txAmpEnablePin(txAmpEnablePin),
        .rxAmpEnablePin(rxAmpEnablePin), .testModulePowerDown(testModulePowerDown),
        .testMode(testMode), .txSelect(txSelect), .freqSetB(freqSetB),
        .synthPowerDown(synthPowerDown), .oscCorePowerDown(oscCorePowerDown),
        .biasPowerDown(biasPowerDown), .oscillatorBypass(oscillatorBypass),
        .sequenceEnable(sequenceEnable), .sequenceCalPolicy(sequenceCalPolicy),
        .sequenceStart(sequenceStart), .sequencePowerDown(sequencePowerDown),
        .calRequest(calRequest), .softResetN(softResetN));

    always #20 clock = ~clock;

    // one-cycle pulses counted at every rising clock edge so none slips by during a frame
    always @(posedge clock) begin
        if (sequenceStart === 1'b1) nStart++;
        if (sequencePowerDown === 1'b1) nPd++;
        if (calRequest === 1'b1) nCal++;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : tick

    task automatic chk(input string nm, input logic [7:0] g, input logic [7:0] e);
        testsRun++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_tmpc_host_model.frame(1'b1, a, d, q);
    endtask : wr

    task automatic rc(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_tmpc_host_model.frame(1'b0, a, 8'h00, q);
        chk("readback", q, e);
    endtask : rc

    task automatic printVerdict();
        $display("comparisons %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : printVerdict

    task automatic resetValues();
        chk("reset pins", {testModulePowerDown, testMode, dataClockPin, txAmpEnablePin,
            rxAmpEnablePin, dataIoPinOe}, 8'h91);
        rc(`TMPC_ADDR_IFC, 8'h00);
        chk("bypass", oscillatorBypass, 8'h00);
        $display("test resetValues done");
    endtask : resetValues

    task automatic decode();
        wr(`TMPC_ADDR_MODE, 8'hcf);
        tick(3);
        chk("decode", {1'b0, txSelect, freqSetB, synthPowerDown, oscCorePowerDown,
            biasPowerDown, sequenceEnable, softResetN}, 8'h7d);
        wr(`TMPC_ADDR_MODE, 8'h45);
        tick(3);
        chk("decode", {1'b0, txSelect, freqSetB, synthPowerDown, oscCorePowerDown,
            biasPowerDown, sequenceEnable, softResetN}, 8'h29);
        rc(`TMPC_ADDR_MODE, 8'h45);
        $display("test decode done");
    endtask : decode

    task automatic softReset();
        wr(`TMPC_ADDR_MODE, 8'h41);
        wr(`TMPC_ADDR_IFC, 8'ha5);
        rc(`TMPC_ADDR_IFC, 8'ha5);
        chk("bypass", {oscillatorBypass, oscCorePowerDown}, 8'h03);
        wr(`TMPC_ADDR_MODE, 8'h40);
        rc(`TMPC_ADDR_IFC, 8'h00);
        rc(`TMPC_ADDR_MODE, 8'h40);
        wr(`TMPC_ADDR_IFC, 8'h12);
        rc(`TMPC_ADDR_IFC, 8'h00);
        wr(`TMPC_ADDR_MODE, 8'h41);
        wr(`TMPC_ADDR_IFC, 8'h12);
        rc(`TMPC_ADDR_IFC, 8'h12);
        wr(7'h7f, 8'hff);
        rc(7'h7f, 8'h00);
        rc(`TMPC_ADDR_IFC, 8'h12);
        $display("test softReset done");
    endtask : softReset

    // every control/polarity pair against both internal amp states
    task automatic amps();
        logic [3:0] v;
        logic on;
        logic [5:0] e;
        for (int i = 0; i < 32; i++) begin
            v = i[4:1];
            on = i[0];
            if (!on) wr(`TMPC_ADDR_IFC, {4'h0, v});
            txOn = on;
            rxOn = on ^ v[0];
            tfEn = on & ~v[0];
            taEn = on & v[0];
            tick(4);
            e[5] = v[3] ? ~(txOn ^ v[1]) : v[1];
            e[4] = v[2] ? ~(rxOn ^ v[0]) : v[0];
            e[3:0] = on ? v : 4'h9;
            chk("amps", {txAmpEnablePin, rxAmpEnablePin, testModulePowerDown, testMode},
                e);
        end
        tfEn = 1'b0;
        taEn = 1'b0;
        $display("test amps done");
    endtask : amps

    task automatic dataPath();
        wr(`TMPC_ADDR_MODE, 8'h01);
        wr(`TMPC_ADDR_IFC, 8'h00);
        rxData = 1'b1;
        pllLock = 1'b1;
        tick(5);
        chk("shared rx", {dataIoPinOe, dataIoPinOut, lockPin, txData}, 8'h0e);
        rxData = 1'b0;
        pllLock = 1'b0;
        tick(5);
        chk("shared rx", {dataIoPinOe, dataIoPinOut, lockPin, txData}, 8'h08);
        wr(`TMPC_ADDR_MODE, 8'h81);
        tick(5);
        chk("shared tx", {dataIoPinOe, txData}, 8'h01);
        dataIoPinIn = 1'b0;
        tick(5);
        chk("shared tx", {dataIoPinOe, txData}, 8'h00);
        wr(`TMPC_ADDR_MODE, 8'h01);
        wr(`TMPC_ADDR_IFC, 8'h40);
        rxData = 1'b1;
        tick(5);
        chk("separate sync", {dataIoPinOe, lockPin}, 8'h01);
        syncMode = 1'b0;
        rxData = 1'b0;
        tick(5);
        chk("separate async", dataClockPin, 8'h00);
        rxData = 1'b1;
        tick(5);
        chk("separate async", dataClockPin, 8'h01);
        syncMode = 1'b1;
        $display("test dataPath done");
    endtask : dataPath

    task automatic gating();
        wr(`TMPC_ADDR_IFC, 8'h20);
        wr(`TMPC_ADDR_MODE, 8'h11);
        tick(5);
        chk("lock gate", dataClockPin, 8'h01);
        pllLock = 1'b1;
        tick(5);
        chk("lock gate", dataClockPin, 8'h00);
        wr(`TMPC_ADDR_MODE, 8'h01);
        pllLock = 1'b0;
        tick(5);
        chk("lock gate off", dataClockPin, 8'h00);
        wr(`TMPC_ADDR_IFC, 8'h10);
        tick(5);
        chk("carrier gate", dataClockPin, 8'h01);
        carrierSense = 1'b1;
        tick(5);
        chk("carrier gate", dataClockPin, 8'h00);
        wr(`TMPC_ADDR_IFC, 8'h00);
        carrierSense = 1'b0;
        tick(5);
        chk("carrier free", dataClockPin, 8'h00);
        syncDataClock = 1'b1;
        tick(5);
        chk("clock pass", dataClockPin, 8'h01);
        syncDataClock = 1'b0;
        $display("test gating done");
    endtask : gating

    // done pulses per policy, with calibration requests expected from the policy
    task automatic seqLayout();
        int n[4] = '{3, 2, 16, 256};
        int e[4] = '{0, 2, 1, 1};
        for (int p = 0; p < 4; p++) begin
            wr(`TMPC_ADDR_MODE, {4'h3, p[1:0], 2'b01});
            tick(3);
            chk("seq layout", {synthPowerDown, oscCorePowerDown, biasPowerDown,
                sequenceEnable, 2'b00, sequenceCalPolicy}, {6'h04, p[1:0]});
            nCal = 0;
            repeat (n[p]) begin
                sequenceDone = 1'b1;
                tick(1);
                sequenceDone = 1'b0;
                tick(2);
            end
            tick(3);
            chk("cal count", nCal[7:0], e[p][7:0]);
        end
        wr(`TMPC_ADDR_MODE, 8'hbd);
        tick(3);
        chk("seq in tx", sequenceEnable, 8'h00);
        $display("test seqLayout done");
    endtask : seqLayout

    task automatic powerDown();
        wr(`TMPC_ADDR_MODE, 8'h31);
        nPd = 0;
        wr(`TMPC_ADDR_MODE, 8'h33);
        chk("pd pulse", nPd[7:0], 8'h01);
        wr(`TMPC_ADDR_MODE, 8'h33);
        chk("pd no rise", nPd[7:0], 8'h01);
        $display("test powerDown done");
    endtask : powerDown

    task automatic triggers();
        wr(`TMPC_ADDR_MODE, 8'h31);
        wr(`TMPC_ADDR_IFC, 8'h40);
        dataIoPinIn = 1'b1;
        tick(5);
        nStart = 0;
        dataIoPinIn = 1'b0;
        tick(10);
        chk("pin start", nStart[7:0], 8'h01);
        dataIoPinIn = 1'b1;
        selUse = 1'b1;
        tick(5);
        nStart = 0;
        dataIoPinIn = 1'b0;
        tick(10);
        chk("pin ignored", nStart[7:0], 8'h00);
        rc(`TMPC_ADDR_MODE, 8'h31);
        chk("select start", nStart[7:0], 8'h01);
        selUse = 1'b0;
        nStart = 0;
        rc(`TMPC_ADDR_MODE, 8'h31);
        chk("select ignored", nStart[7:0], 8'h00);
        $display("test triggers done");
    endtask : triggers

    // bounded run: a hang counts as a mismatch
    initial begin
        repeat (60000) @(posedge clock);
        fails++;
        $display("MISMATCH run length expected finish seen timeout");
        printVerdict();
    end

    initial begin
        tick(8);
        reset = 1'b0;
        tick(4);
        resetValues();
        decode();
        softReset();
        amps();
        dataPath();
        gating();
        seqLayout();
        powerDown();
        triggers();
        printVerdict();
    end
endmodule : tmpc_mode_pin_regs_bench
